/* File: verilog/lcd_defines.vh */
`ifndef LCD_DEFINES_VH
`define LCD_DEFINES_VH

// register indexes; byte address is four times the index
`define IDX_MODE 8'hdc
`define IDX_RAM_FIRST 8'he0
`define IDX_RAM_LAST 8'hf7
`define IDX_STATUS 8'hf8
`define ADDR_HI_ZERO 2'h0

// display ram geometry
`define RAM_DEPTH 24
`define RAM_AW 5
`define BYTES_PER_COM 3'h6
`define LAST_BYTE 3'h5
`define SEG_LOW_BIT 3

// mode register fields and reset value
`define MODE_RESET 8'h00
`define MUX_MSB 7
`define MUX_LSB 6
`define OSC_MSB 5
`define OSC_LSB 3
`define FRM_MSB 2
`define FRM_LSB 0

// multiplexing ratio codes
`define MUX_QUARTER 2'h0
`define MUX_STATIC 2'h1
`define MUX_HALF 2'h2
`define MUX_THIRD 2'h3

// oscillator divider codes and divisors
`define OSC_DIV32 3'h3
`define OSC_DIV64 3'h4
`define OSC_DIV128 3'h5
`define OSC_DIV256 3'h6
`define DIV_NONE 10'h000
`define DIV_32 10'h020
`define DIV_64 10'h040
`define DIV_128 10'h080
`define DIV_256 10'h100

// base frame divisors for codes 0..6, code 7 reserved
`define FRM_RESERVED 3'h7
`define DIV_512 10'h200
`define DIV_386 10'h182
`define DIV_192 10'h0c0
`define DIV_96 10'h060

// drive level codes
`define LVL_GND 2'h0
`define LVL_THIRD 2'h1
`define LVL_TWO_THIRD 2'h2
`define LVL_FULL 2'h3

// status register bits
`define STAT_ACTIVE 0
`define STAT_COM_LSB 1
`define STAT_COM_MSB 2
`define STAT_POL 3

`endif

/* File: verilog/lcd_ram.v */
`timescale 1ns/1ps
`include "lcd_defines.vh"

// display memory: cpu port and scan read port, registered reads, no reset
module lcd_ram
(
  input wire clk,
  input wire cpu_we,
  input wire [4:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  output reg [7:0] cpu_rdata,
  input wire [4:0] scan_addr,
  output reg [7:0] scan_rdata
);

  reg [7:0] mem [0:`RAM_DEPTH-1];

  // contents are left arbitrary by reset
  always @(posedge clk)
  begin
    if (cpu_we)
      mem[cpu_addr] <= cpu_wdata;
    cpu_rdata <= mem[cpu_addr];
    scan_rdata <= mem[scan_addr];
  end

endmodule // lcd_ram

/* File: verilog/lcd_clk_div.v */
`timescale 1ns/1ps
`include "lcd_defines.vh"

// counts step pulses and emits one tick every divisor steps
module lcd_clk_div
(
  input wire clk,
  input wire srst,
  input wire run,
  input wire step,
  input wire [9:0] divisor,
  output reg tick
);

  reg [9:0] cnt_q;

  // restart whenever stopped so the first tick is a full period away
  always @(posedge clk)
  begin
    if (srst || !run)
    begin
      cnt_q <= 10'h000;
      tick <= 1'b0;
    end
    else if (step && (cnt_q == divisor - 10'h001))
    begin
      cnt_q <= 10'h000;
      tick <= 1'b1;
    end
    else
    begin
      if (step)
        cnt_q <= cnt_q + 10'h001;
      tick <= 1'b0;
    end
  end

endmodule // lcd_clk_div

/* File: verilog/lcd_segment_controller.v */
// What this block does
// - block makes all common and segment timing
// - bias divider off whenever display is off
// - thirds driven; half mode needs pins tied
// - one ram bit drives one element
// - bit one lights element, zero keeps off
// - ram at e0..f7, six bytes per common
// - segments ascend from lsb, low three unused
// - display ram not initialised by reset
// - unused common bytes stay plain storage
// - stop mode grounds every output
// - mode register at dc, three fields
// - ratio field sets scanned backplane count
// - oscillator field divides clock to reference
// - frame field divides reference, 111 reserved
// - ratio codes 00=4,01=1,10=2,11=3 backplanes
// - osc codes 000 off, 011..110 divide 32..256
// - frame rate is base over backplane count
// - oscillator failure grounds every output
`timescale 1ns/1ps
`include "lcd_defines.vh"

module lcd_segment_controller
(
  input wire clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire stop_mode,
  input wire osc_fail_async,
  output reg [7:0] backplane_lvl,
  output reg [89:0] segment_lvl,
  output reg bias_divider_en,
  output reg half_bias_sel
);

  // number of scanned backplanes for a ratio code
  function [2:0] com_count;
    input [1:0] code;
    begin
      case (code)
        `MUX_STATIC: com_count = 3'h1;
        `MUX_HALF: com_count = 3'h2;
        `MUX_THIRD: com_count = 3'h3;
        default: com_count = 3'h4;
      endcase
    end
  endfunction

  // main clock divisor, zero means display clock stopped
  function [9:0] osc_div;
    input [2:0] code;
    begin
      case (code)
        `OSC_DIV32: osc_div = `DIV_32;
        `OSC_DIV64: osc_div = `DIV_64;
        `OSC_DIV128: osc_div = `DIV_128;
        `OSC_DIV256: osc_div = `DIV_256;
        default: osc_div = `DIV_NONE;
      endcase
    end
  endfunction

  // reference divisor for the base frame
  function [9:0] frame_div;
    input [2:0] code;
    begin
      case (code)
        3'h0: frame_div = `DIV_512;
        3'h1: frame_div = `DIV_386;
        3'h2: frame_div = `DIV_256;
        3'h3: frame_div = `DIV_192;
        3'h4: frame_div = `DIV_128;
        3'h5: frame_div = `DIV_96;
        3'h6: frame_div = `DIV_64;
        default: frame_div = `DIV_NONE;
      endcase
    end
  endfunction

  // level on one backplane
  function [1:0] com_level;
    input sel;
    input pol;
    input is_static;
    begin
      if (sel || is_static)
        com_level = pol ? `LVL_FULL : `LVL_GND;
      else
        com_level = pol ? `LVL_THIRD : `LVL_TWO_THIRD;
    end
  endfunction

  // level on one segment against the selected backplane
  function [1:0] seg_level;
    input on;
    input pol;
    input is_static;
    begin
      if (on)
        seg_level = pol ? `LVL_GND : `LVL_FULL;
      else if (is_static)
        seg_level = pol ? `LVL_FULL : `LVL_GND;
      else
        seg_level = pol ? `LVL_TWO_THIRD : `LVL_THIRD;
    end
  endfunction

  reg [7:0] mode_q;
  reg ack_q;
  reg rd_ram_q;
  reg err_q;
  reg [31:0] prdata_q;
  reg fail_meta_q;
  reg fail_q;
  reg [1:0] com_q;
  reg pol_q;
  reg [2:0] fetch_q;
  reg [2:0] fetch_prev_q;
  reg fetch_vld_q;
  reg [47:0] seg_bytes_q;
  wire [7:0] cpu_rdata;
  wire [7:0] scan_rdata;
  wire ref_tick;
  wire frame_tick;

  // apb decode on the word index
  wire [7:0] idx = paddr[9:2];
  wire in_page = (paddr[11:10] == `ADDR_HI_ZERO);
  wire hit_mode = in_page && (idx == `IDX_MODE);
  wire hit_stat = in_page && (idx == `IDX_STATUS);
  wire hit_ram = in_page && (idx >= `IDX_RAM_FIRST) && (idx <= `IDX_RAM_LAST);
  wire [7:0] ram_off = idx - `IDX_RAM_FIRST;
  wire access = psel && penable;
  wire first = access && !ack_q;
  wire done = access && ack_q;

  // mode fields
  wire [1:0] mux_sel = mode_q[`MUX_MSB:`MUX_LSB];
  wire [2:0] osc_sel = mode_q[`OSC_MSB:`OSC_LSB];
  wire [2:0] frm_sel = mode_q[`FRM_MSB:`FRM_LSB];
  wire [2:0] n_com = com_count(mux_sel);
  wire [9:0] osc_divisor = osc_div(osc_sel);
  wire [9:0] frm_divisor = frame_div(frm_sel);
  wire is_static = (mux_sel == `MUX_STATIC);

  // display runs only with a clock, a legal frame code, no stop, no failure
  wire drv_on = (osc_divisor != `DIV_NONE) && (frm_sel != `FRM_RESERVED)
    && !stop_mode && !fail_q;

  // scan read address: six bytes per backplane
  wire [4:0] scan_addr = {com_q, 3'h0} - {2'h0, com_q, 1'b0}
    + {2'h0, fetch_q};

  // one wait state on every transfer, then ready
  assign pready = done;
  assign pslverr = done && err_q;
  assign prdata = rd_ram_q ? {24'h000000, cpu_rdata} : prdata_q;

  // apb handshake and read data capture
  always @(posedge clk)
  begin
    if (srst)
    begin
      ack_q <= 1'b0;
      rd_ram_q <= 1'b0;
      err_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= first;
      if (first)
      begin
        rd_ram_q <= hit_ram && !pwrite;
        err_q <= !(hit_mode || hit_stat || hit_ram);
        if (hit_mode)
          prdata_q <= {24'h000000, mode_q};
        else if (hit_stat)
          prdata_q <= {28'h0000000, pol_q, com_q, drv_on};
        else
          prdata_q <= 32'h00000000;
      end
    end
  end

  // mode register, written at the completing edge
  always @(posedge clk)
  begin
    if (srst)
      mode_q <= `MODE_RESET;
    else if (done && pwrite && hit_mode)
      mode_q <= pwdata[7:0];
  end

  // failure flag from the clock supervisor, two-stage sync
  always @(posedge clk)
  begin
    if (srst)
    begin
      fail_meta_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else
    begin
      fail_meta_q <= osc_fail_async;
      fail_q <= fail_meta_q;
    end
  end

  // display memory, every byte plain storage whatever the ratio
  lcd_ram u_ram
  (
    .clk(clk),
    .cpu_we(done && pwrite && hit_ram),
    .cpu_addr(ram_off[4:0]),
    .cpu_wdata(pwdata[7:0]),
    .cpu_rdata(cpu_rdata),
    .scan_addr(scan_addr),
    .scan_rdata(scan_rdata)
  );

  // main clock down to the reference
  lcd_clk_div u_ref_div
  (
    .clk(clk),
    .srst(srst),
    .run(drv_on),
    .step(1'b1),
    .divisor(osc_divisor),
    .tick(ref_tick)
  );

  // reference down to the base frame rate
  lcd_clk_div u_frame_div
  (
    .clk(clk),
    .srst(srst),
    .run(drv_on),
    .step(ref_tick),
    .divisor(frm_divisor),
    .tick(frame_tick)
  );

  // backplane stepping, one per base tick, inversion per full frame
  always @(posedge clk)
  begin
    if (srst || !drv_on)
    begin
      com_q <= 2'h0;
      pol_q <= 1'b0;
    end
    else if (frame_tick)
    begin
      if ({1'b0, com_q} >= n_com - 3'h1)
      begin
        com_q <= 2'h0;
        pol_q <= !pol_q;
      end
      else
        com_q <= com_q + 2'h1;
    end
  end

  // continuous fetch of the six bytes of the current backplane
  always @(posedge clk)
  begin
    if (srst)
    begin
      fetch_q <= 3'h0;
      fetch_prev_q <= 3'h0;
      fetch_vld_q <= 1'b0;
      seg_bytes_q <= 48'h000000000000;
    end
    else
    begin
      fetch_q <= (fetch_q == `LAST_BYTE) ? 3'h0 : fetch_q + 3'h1;
      fetch_prev_q <= fetch_q;
      fetch_vld_q <= drv_on;
      if (fetch_vld_q)
        seg_bytes_q[fetch_prev_q*8 +: 8] <= scan_rdata;
    end
  end

  // output levels, all grounded while the display is off
  always @(posedge clk)
  begin : drive
    integer i;
    if (srst || !drv_on)
    begin
      backplane_lvl <= 8'h00;
      segment_lvl <= 90'h0;
      bias_divider_en <= 1'b0;
      half_bias_sel <= 1'b0;
    end
    else
    begin
      bias_divider_en <= 1'b1;
      half_bias_sel <= (mux_sel == `MUX_HALF);
      for (i = 0; i < 4; i = i + 1)
      begin
        if (i < n_com)
          backplane_lvl[i*2 +: 2] <= com_level(com_q == i, pol_q, is_static);
        else
          backplane_lvl[i*2 +: 2] <= `LVL_GND;
      end
      for (i = 0; i < 45; i = i + 1)
        segment_lvl[i*2 +: 2] <= seg_level(seg_bytes_q[i + `SEG_LOW_BIT], pol_q,
          is_static);
    end
  end

endmodule // lcd_segment_controller

/* File: dv/lcd_panel_model.sv */
`timescale 1ns/1ps

// passive glass: an element is lit when the full supply lies across it
module lcd_panel_model
(
  input wire [7:0] backplane_lvl,
  input wire [89:0] segment_lvl,
  input wire half_bias_sel,
  output logic [44:0] lit
);
  // third pins are tied together here when half bias is selected
  wire [1:0] bp = backplane_lvl[1:0];

  // voltage in sixths of the supply; tied third pins settle at half
  function automatic int volt(input logic [1:0] l, input logic half);
    if (half && (l == 2'h1 || l == 2'h2))
      return 3;
    return 2 * l;
  endfunction

  // one lit flag per segment against backplane_1
  always_comb
  begin
    for (int j = 0; j < 45; j++)
      lit[j] = (volt(segment_lvl[2*j+:2], half_bias_sel) - volt(bp, half_bias_sel) == 6) ||
               (volt(bp, half_bias_sel) - volt(segment_lvl[2*j+:2], half_bias_sel) == 6);
  end
endmodule // lcd_panel_model

/* File: dv/lcd_segment_controller_assertions.sv */
`timescale 1ns/1ps

module lcd_segment_controller_assertions
(
  input wire clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire stop_mode,
  input wire osc_fail_async,
  input wire [7:0] backplane_lvl,
  input wire [89:0] segment_lvl,
  input wire bias_divider_en,
  input wire half_bias_sel
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // address decode for the error flag
  wire [7:0] idx = paddr[9:2];
  wire mapped = paddr[11:10] == 2'h0 && (idx == 8'hdc || (idx >= 8'he0 && idx <= 8'hf8));
  wire grounded = backplane_lvl == 8'h00 && segment_lvl == 90'h0;

  a_stop_grounds:
    assert property (stop_mode |=> grounded) else $error("stop left outputs driven");
  a_stop_bias_off:
    assert property (stop_mode |=> !bias_divider_en) else $error("bias on in stop");
  a_fail_grounds:
    assert property (osc_fail_async [*3] |=> grounded) else $error("fail left outputs driven");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_wait_state:
    assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("wait state");
  a_map_error:
    assert property (pready |-> pslverr == !mapped) else $error("error flag vs map");
  a_read_upper:
    assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
  a_reset_quiet:
    assert property ($fell(srst) |-> grounded && !bias_divider_en) else $error("reset state");
endmodule // lcd_segment_controller_assertions

bind lcd_segment_controller lcd_segment_controller_assertions u_chk (.clk(clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
  .osc_fail_async(osc_fail_async), .backplane_lvl(backplane_lvl), .segment_lvl(segment_lvl),
  .bias_divider_en(bias_divider_en), .half_bias_sel(half_bias_sel));

/* File: dv/lcd_segment_controller_tb.sv */
`timescale 1ns/1ps

module lcd_segment_controller_tb;
  logic clk, srst, psel, penable, pwrite, stop_mode, osc_fail_async, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] backplane_lvl, rd, m, mem[24];
  logic [89:0] segment_lvl;
  logic [44:0] lit;
  logic bias_divider_en, half_bias_sel, er, act;
  logic [7:0] holes[3] = '{8'hdb, 8'hdf, 8'hf9};
  int bad_count, n_compared, i, k;

  lcd_segment_controller DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_mode(stop_mode), .osc_fail_async(osc_fail_async),
    .backplane_lvl(backplane_lvl), .segment_lvl(segment_lvl),
    .bias_divider_en(bias_divider_en), .half_bias_sel(half_bias_sel));
  lcd_panel_model panel (.backplane_lvl(backplane_lvl), .segment_lvl(segment_lvl),
    .half_bias_sel(half_bias_sel), .lit(lit));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // one apb transfer, held until ready is seen at a rising edge
  task automatic apb(input bit wr, input [7:0] idx, input [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    // ready and data are taken at the completing rising edge; watchdog ends a hang
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  // wait cycles, then settle past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // lit pattern of backplane_1: segment_first sits at bit 3 of the first byte
  function automatic [44:0] exp_lit();
    logic [47:0] f;
    f = {mem[5], mem[4], mem[3], mem[2], mem[1], mem[0]};
    return f[47:3];
  endfunction

  // expected backplane levels: scan position c, polarity p, n backplanes in use
  function automatic [7:0] exp_bp(input int c, input bit p, input int n);
    exp_bp = 8'h00;
    for (int b = 0; b < n; b++)
      exp_bp[2*b+:2] = (b == c) ? (p ? 2'h3 : 2'h0) : (p ? 2'h1 : 2'h2);
  endfunction

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog against a hang, about twice the planned run length
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    summarize;
  end

  initial
  begin
    {srst, psel, penable, pwrite, paddr, pwdata, stop_mode, osc_fail_async} = '0;
    srst = 1'b1;
    i = $urandom(32'h15c1);
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    apb(0, 8'hdc, 8'h00);
    chk(rd === 8'h00 && er === 1'b0, "mode reset value");
    // whole display memory written and read back
    for (i = 0; i < 24; i++)
    begin
      mem[i] = 8'($urandom);
      apb(1, 8'he0 + 8'(i), mem[i]);
    end
    for (i = 0; i < 24; i++)
    begin
      apb(0, 8'he0 + 8'(i), 8'h00);
      chk(rd === mem[i] && er === 1'b0, "ram readback");
    end
    // holes around the map are refused
    foreach (holes[j])
    begin
      apb(1, holes[j], 8'h5a);
      chk(er === 1'b1, "unmapped write");
    end
    apb(0, 8'hf9, 8'h00);
    chk(er === 1'b1 && rd === 8'h00, "unmapped read");
    // every oscillator code, plus the reserved frame code
    for (i = 0; i < 9; i++)
    begin
      m = (i < 8) ? {2'($urandom_range(3)), 3'(i), 3'($urandom_range(6))} : 8'h5f;
      act = m[5:3] >= 3'h3 && m[5:3] <= 3'h6 && m[2:0] != 3'h7;
      apb(1, 8'hdc, m);
      apb(0, 8'hdc, 8'h00);
      chk(rd === m, "mode readback");
      cyc(3);
      chk(bias_divider_en === act, "bias enable");
      chk(half_bias_sel === (act && m[7:6] == 2'h2), "half bias");
    end
    // static ratio, div 32 and 64: panel shows first backplane bytes
    for (k = 0; k < 2; k++)
    begin
      apb(1, 8'hdc, k ? 8'h66 : 8'h5e);
      for (i = 0; i < 6; i++)
      begin
        mem[i] = 8'($urandom);
        apb(1, 8'he0 + 8'(i), mem[i]);
      end
      cyc(2100);
      chk(lit === exp_lit(), "lit pattern");
    end
    @(posedge clk);
    stop_mode <= 1'b1;
    cyc(2);
    chk(backplane_lvl === 8'h00 && segment_lvl === 90'h0, "stop grounds");
    chk(bias_divider_en === 1'b0, "bias off in stop");
    @(posedge clk);
    stop_mode <= 1'b0;
    cyc(2100);
    chk(lit === exp_lit(), "lit after stop");
    @(posedge clk);
    osc_fail_async <= 1'b1;
    cyc(4);
    chk(backplane_lvl === 8'h00 && segment_lvl === 90'h0, "fail grounds");
    @(posedge clk);
    osc_fail_async <= 1'b0;
    // quarter ratio from a clean start: one backplane step per 2048 clocks
    apb(1, 8'hdc, 8'h00);
    apb(1, 8'hdc, 8'h1e);
    cyc(1000);
    for (k = 0; k < 5; k++)
    begin
      chk(backplane_lvl === exp_bp(k % 4, k >= 4, 4), "backplane scan");
      apb(0, 8'hf8, 8'h00);
      chk(rd[3:0] === {k >= 4, 2'(k % 4), 1'b1} && er === 1'b0, "status");
      cyc(2044);
    end
    summarize;
  end
endmodule // lcd_segment_controller_tb
